// >>> counter_array_pkg.sv
// package: register offsets, fields, resets and carriers for the counter array timebase block
package counter_array_pkg;

    // ==========================================
    // register offsets (byte addresses on the register port)
    localparam logic [7:0] ADDR_COUNT_LOW    = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH   = 8'h01;
    localparam logic [7:0] ADDR_MODE         = 8'h02;
    localparam logic [7:0] ADDR_FLAGS        = 8'h03;
    localparam logic [7:0] ADDR_MODULE_IEN   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_CTRL     = 8'h05;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h06;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h07;
    localparam logic [7:0] ADDR_MODULE_IOEN  = 8'h08;

    // ==========================================
    // mode register fields
    localparam int MODE_IEN_BIT    = 0;
    localparam int MODE_TB_LSB     = 1;
    localparam int MODE_TB_MSB     = 3;
    localparam int MODE_WDOG_BIT   = 6;
    localparam int MODE_IDLE_BIT   = 7;
    localparam logic [7:0] MODE_RESET = 8'h40; // watchdog function on after reset

    // flags register: bits 4:0 module flags, bit 7 overflow flag
    localparam int FLAG_OVF_BIT    = 7;
    localparam int NUM_MODULES     = 5;

    // irq control: bit0 global enable, bit1 array enable
    localparam int CTRL_GLOBAL_BIT = 0;
    localparam int CTRL_ARRAY_BIT  = 1;

    // sticky status: bit0 overflow, bit1 module event, bit2 cpu request high
    localparam int ST_OVF_BIT      = 0;
    localparam int ST_MOD_BIT      = 1;
    localparam int ST_REQ_BIT      = 2;

    // ==========================================
    // timebase codes and divider counts
    localparam logic [2:0] TB_DIV12   = 3'h0;
    localparam logic [2:0] TB_DIV4    = 3'h1;
    localparam logic [2:0] TB_TIMER0  = 3'h2;
    localparam logic [2:0] TB_EXTIN   = 3'h3;
    localparam logic [2:0] TB_SYSCLK  = 3'h4;
    localparam logic [2:0] TB_EXTOSC8 = 3'h5;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [2:0] OSC8_LAST  = 3'h7;

    // register port carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage

// >>> counter_array_timebase.sv
// counter array 16-bit timebase counter, snapshot read and interrupt combining
// ==========================================
// overview
// one system clock drives every flop in this block
// all slower rates are one-cycle tick enables, never derived clocks
// the timebase mux picks one tick source from the select field
// idle gating can suppress the tick while the cpu idles
// a qualified tick advances the 16-bit count by exactly one
// the count wrap from all ones to zero sets the overflow flag
// module event rising edges set the per-module flags
// flags combine with their enables into one array request
// the cpu request also needs the global and array enables
// a sticky status word with a mask drives a second level output
//
// ==========================================
// timebase sources
// code 0: divide-by-twelve counter, tick on its last state
// code 1: divide-by-four counter, tick on its last state
// code 2: timer0 overflow pulse, one tick per pulse
// code 3: external count input, synchronised, falling edge ticks
// code 4: every system clock cycle ticks
// code 5: external oscillator, synchronised, every eighth rising edge ticks
// codes 6 and 7: reserved, no ticks at all
//
// ==========================================
// limitations
// the external count input must stay under a quarter of the clock rate
// the oscillator input is sampled, so it must stay under half the clock rate
// both synchronised sources lag their pin by two clock cycles
// a count write in a tick cycle wins and that tick is lost
// the high byte snapshot is only refreshed by a low byte read
// a high byte read without a prior low read returns a stale snapshot
//
// ==========================================
// register port
// writes take effect at the strobe edge, no wait states
// read data stand for one cycle after the read strobe, zero otherwise
// reads change nothing except the snapshot on a low byte read
// unmapped addresses read as zero and ignore writes
//
// ==========================================
// interrupt paths
// cpu request is combinational from flags, enables and control bits
// sticky status bits are write-one-to-clear, a new event wins
// status bit 0 marks a wrap, bit 1 any module event
// status bit 2 marks a cycle with the cpu request high
// the interrupt output is high while any unmasked status bit is set
`timescale 1ns/1ns
module counter_array_timebase
    import counter_array_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // timebase sources
    input  wire logic       timer0_ovf_in,
    input  wire logic       ext_count_in,
    input  wire logic       ext_osc_in,
    input  wire logic       cpu_idle_in,
    // module events and io lines
    input  wire logic [4:0] module_event_in,
    input  wire logic [4:0] module_io_line_in,
    output logic      [4:0] pin_drive_out,
    output logic      [4:0] pin_route_out,
    // interrupt outputs
    output logic            cpu_irq_out,
    output logic            irq_out
);

    // ==========================================
    // state
    reg_req_s    req;
    logic [15:0] count_q;
    logic [7:0]  snap_q;
    logic [7:0]  mode_q;
    logic [4:0]  mod_flag_q;
    logic [4:0]  mod_ien_q;
    logic [4:0] mod_ioen_q;
    logic [1:0]  ctrl_q;
    logic [2:0]  status_q;
    logic [2:0]  mask_q;
    logic [3:0]  div12_q;
    logic [1:0]  div4_q;
    logic [1:0]  eci_sync_q;
    logic        eci_last_q;
    logic [2:0]  osc_div_q;
    logic [1:0]  osc_sync_q;
    logic        osc_last_q;
    logic        osc_rise;
    logic        flags_ovf_q;
    logic        tick;
    logic        run;
    logic        wrap;
    logic        ovf_flag;
    logic        array_req;
    logic [2:0]  tb_sel;
    logic        wr_mode;
    logic        wr_flags;
    logic        wr_count_lo;
    logic        wr_count_hi;
    logic [4:0]  mod_rise;
    logic [4:0]  mod_last_q;

    assign req.addr  = reg_addr_in;
    assign req.wdata = reg_wdata_in;
    assign req.wr    = reg_wr_in;
    assign req.rd    = reg_rd_in;

    assign tb_sel   = mode_q[MODE_TB_MSB:MODE_TB_LSB];
    assign ovf_flag = flags_ovf_q;

    // ==========================================
    // register map
    // 0x00 count low byte, writable only with the watchdog bit clear
    // 0x01 count high byte read returns the snapshot, same write lock
    // 0x02 mode: bit0 overflow irq enable, bits 3:1 timebase select
    // 0x02 mode: bit6 watchdog, cleared by writing zero, set by reset only
    // 0x02 mode: bit7 idle stop, bits 5:4 read as zero
    // 0x03 flags: bit7 overflow, bits 4:0 module events, set wins
    // 0x04 module flag interrupt enables, bits 4:0
    // 0x05 interrupt control: bit0 global, bit1 array enable
    // 0x06 sticky status, write one to clear
    // 0x07 status mask, same layout as status
    // 0x08 module io line enables, bits 4:0
    //
    // ==========================================
    // write decode
    assign wr_mode     = req.wr && (req.addr == ADDR_MODE);
    assign wr_flags    = req.wr && (req.addr == ADDR_FLAGS);
    assign wr_count_lo = req.wr && (req.addr == ADDR_COUNT_LOW) && !mode_q[MODE_WDOG_BIT];
    assign wr_count_hi = req.wr && (req.addr == ADDR_COUNT_HIGH) && !mode_q[MODE_WDOG_BIT];

    // ==========================================
    // fixed dividers for clk/12 and clk/4
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            div12_q <= 4'h0;
            div4_q  <= 2'h0;
        end else begin
            div12_q <= (div12_q == DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
            div4_q  <= div4_q + 2'h1;
        end
    end

    // external count input: two-stage sync then edge history
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            eci_sync_q <= 2'b11;
            eci_last_q <= 1'b1;
        end else begin
            eci_sync_q <= {eci_sync_q[0], ext_count_in};
            eci_last_q <= eci_sync_q[1];
        end
    end

    // oscillator rising edge seen after the synchroniser
    assign osc_rise = osc_sync_q[1] & ~osc_last_q;

    // oscillator synchronised, then divided by eight in the clock domain
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            osc_sync_q <= 2'b00;
            osc_last_q <= 1'b0;
            osc_div_q  <= 3'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[0], ext_osc_in};
            osc_last_q <= osc_sync_q[1];
            if (osc_rise) begin
                osc_div_q <= (osc_div_q == OSC8_LAST) ? 3'h0 : osc_div_q + 3'h1;
            end
        end
    end

    // ==========================================
    // timebase selection
    always_comb begin
        case (tb_sel)
            TB_DIV12:   tick = (div12_q == DIV12_LAST);
            TB_DIV4:    tick = (div4_q == DIV4_LAST);
            TB_TIMER0:  tick = timer0_ovf_in;
            TB_EXTIN:   tick = eci_last_q & ~eci_sync_q[1];
            TB_SYSCLK:  tick = 1'b1;
            TB_EXTOSC8: tick = osc_rise && (osc_div_q == OSC8_LAST);
            default:    tick = 1'b0; // reserved codes never count
        endcase
    end

    assign run  = tick && !(cpu_idle_in && mode_q[MODE_IDLE_BIT]);
    assign wrap = run && (count_q == 16'hffff);

    // ==========================================
    // one 16-bit counter, two bytes
    // counter; reads never touch it
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= 16'h0000;
        end else if (wr_count_lo) begin
            count_q[7:0] <= req.wdata;
        end else if (wr_count_hi) begin
            count_q[15:8] <= req.wdata;
        end else if (run) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // high byte snapshot on low read
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            snap_q <= 8'h00;
        end else if (req.rd && req.addr == ADDR_COUNT_LOW) begin
            snap_q <= count_q[15:8];
        end
    end

    // ==========================================
    // mode register; watchdog bit clears only, sets only via reset
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= {req.wdata[7], req.wdata[6] & mode_q[6], 2'b00,
                       req.wdata[3:0]};
        end
    end

    // event flags set regardless of enables
    assign mod_rise = module_event_in & ~mod_last_q;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mod_last_q  <= 5'h00;
            mod_flag_q  <= 5'h00;
            flags_ovf_q <= 1'b0;
        end else begin
            mod_last_q <= module_event_in;
            // set beats software clear in the same cycle
            if (wr_flags) begin
                mod_flag_q <= req.wdata[4:0] | mod_rise;
            end else begin
                mod_flag_q <= mod_flag_q | mod_rise;
            end
            // wrap sets overflow; only software clears
            if (wrap) begin
                flags_ovf_q <= 1'b1;
            end else if (wr_flags) begin
                flags_ovf_q <= req.wdata[FLAG_OVF_BIT];
            end
        end
    end

    // enables and routing registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mod_ien_q  <= 5'h00;
            mod_ioen_q <= 5'h00;
            ctrl_q     <= 2'b00;
            mask_q     <= 3'b000;
        end else if (req.wr) begin
            if (req.addr == ADDR_MODULE_IEN)  mod_ien_q  <= req.wdata[4:0];
            if (req.addr == ADDR_MODULE_IOEN) mod_ioen_q <= req.wdata[4:0];
            if (req.addr == ADDR_IRQ_CTRL)    ctrl_q     <= req.wdata[1:0];
            if (req.addr == ADDR_IRQ_MASK)    mask_q     <= req.wdata[2:0];
        end
    end

    // ==========================================
    // interrupt combining
    // each flag gated by its own enable
    assign array_req = (ovf_flag & mode_q[MODE_IEN_BIT]) | (|(mod_flag_q & mod_ien_q));
    assign cpu_irq_out = array_req & ctrl_q[CTRL_GLOBAL_BIT] & ctrl_q[CTRL_ARRAY_BIT];

    // sticky status: write one to clear, set wins
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= 3'b000;
        end else begin
            status_q <= (status_q & ~((req.wr && req.addr == ADDR_IRQ_STATUS) ?
                         req.wdata[2:0] : 3'b000))
                        | {cpu_irq_out, |mod_rise, wrap};
        end
    end
    assign irq_out = |(status_q & mask_q);

    // io lines routed only when enabled
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pin_drive_out <= 5'h00;
            pin_route_out <= 5'h00;
        end else begin
            pin_drive_out <= module_io_line_in & mod_ioen_q;
            pin_route_out <= mod_ioen_q;
        end
    end

    // ==========================================
    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_COUNT_LOW:   reg_rdata_out <= count_q[7:0];
                ADDR_COUNT_HIGH:  reg_rdata_out <= snap_q;
                ADDR_MODE:        reg_rdata_out <= mode_q;
                ADDR_FLAGS:       reg_rdata_out <= {flags_ovf_q, 2'b00, mod_flag_q};
                ADDR_MODULE_IEN:  reg_rdata_out <= {3'b000, mod_ien_q};
                ADDR_IRQ_CTRL:    reg_rdata_out <= {6'h00, ctrl_q};
                ADDR_IRQ_STATUS:  reg_rdata_out <= {5'h00, status_q};
                ADDR_IRQ_MASK:    reg_rdata_out <= {5'h00, mask_q};
                ADDR_MODULE_IOEN: reg_rdata_out <= {3'b000, mod_ioen_q};
                default:          reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

endmodule

// >>> counter_array_timebase_sva.sv
// checker: register port and interrupt output properties of the timebase block
`timescale 1ns/1ns
module counter_array_checker
    import counter_array_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // watched outputs
    input wire logic [4:0] pin_route_out,
    input wire logic       cpu_irq_out,
    input wire logic       irq_out
);
    logic [7:0] mode_q;
    logic [7:0] ctrl_q;
    logic [7:0] mask_q;
    logic [7:0] ien_q;

    // ==========================================
    // shadow copies of the control registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= MODE_RESET;
            ctrl_q <= 8'h00;
            mask_q <= 8'h00;
            ien_q  <= 8'h00;
        end else if (reg_wr_in) begin
            if (reg_addr_in == ADDR_MODE) mode_q <= reg_wdata_in;
            if (reg_addr_in == ADDR_IRQ_CTRL) ctrl_q <= reg_wdata_in;
            if (reg_addr_in == ADDR_IRQ_MASK) mask_q <= reg_wdata_in;
            if (reg_addr_in == ADDR_MODULE_IEN) ien_q <= reg_wdata_in;
        end
    end

    // ==========================================
    // properties
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_mode_read;
        reg_rd_in && reg_addr_in == ADDR_MODE;
    endsequence
    sequence s_ioen_write;
        reg_wr_in && reg_addr_in == ADDR_MODULE_IOEN;
    endsequence
    a_rdata_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside read slot");
    a_unmapped_zero:
        assert property (reg_rd_in && reg_addr_in > ADDR_MODULE_IOEN |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_mode_read:
        assert property (s_mode_read |=> reg_rdata_out[3:0] == $past(mode_q[3:0]))
        else $error("mode readback differs");
    a_route_copy:
        assert property (s_ioen_write |=> ##1 pin_route_out == $past(reg_wdata_in[4:0], 2))
        else $error("route enables not taken from write");
    a_route_hold:
        assert property (!$past(reg_wr_in && reg_addr_in == ADDR_MODULE_IOEN, 2)
                         |-> $stable(pin_route_out))
        else $error("route enables moved without write");
    a_cpu_irq_gate: assert property (cpu_irq_out |-> ctrl_q[CTRL_GLOBAL_BIT] && ctrl_q[CTRL_ARRAY_BIT])
        else $error("cpu request without both enables");
    a_irq_source: assert property (cpu_irq_out |-> mode_q[MODE_IEN_BIT] || ien_q[4:0] != 5'h00)
        else $error("cpu request with no flag enable");
    a_mask_gates: assert property (irq_out |-> mask_q[2:0] != 3'h0)
        else $error("interrupt line high with all masked");
endmodule

bind counter_array_timebase counter_array_checker counter_array_checker_i (.clk_sys_in, .rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pin_route_out,
    .cpu_irq_out, .irq_out);

// >>> count_source_model.sv
// model: external count input and oscillator sources beside the block
`timescale 1ns/1ns
module count_source_model (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // generated sources
    output logic      ext_count_out,
    output logic      ext_osc_out
);
    logic [2:0] phase_q;

    // free running phase counter
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end
    assign ext_count_out = phase_q[2];
    assign ext_osc_out   = phase_q[1];
endmodule

// >>> tb_top.sv
// testbench: register level scenarios for the counter array timebase block
`timescale 1ns/1ns
module tb_top
    import counter_array_pkg::*;
;
    logic       clk_sys_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic       timer0_ovf_in = 1'b0;
    logic       cpu_idle_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [4:0] module_event_in = 5'h00;
    logic [4:0] module_io_line_in = 5'h11;
    logic [7:0] reg_rdata_out, a, d;
    logic [4:0] pin_drive_out, pin_route_out;
    logic       ext_count_in, ext_osc_in, cpu_irq_out, irq_out;
    int         err_total = 0;
    int         cmp_count = 0;
    logic [7:0] mode_tab [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h88};
    logic [7:0] rate_tab [9] = '{8'h08, 8'h18, 8'h00, 8'h0c, 8'h60, 8'h03, 8'h00, 8'h00, 8'h00};

    // ==========================================
    // clock, design and source model
    always #25 clk_sys_in = ~clk_sys_in;
    counter_array_timebase counter_array_timebase_i (.clk_sys_in, .rst_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .timer0_ovf_in, .ext_count_in,
        .ext_osc_in, .cpu_idle_in, .module_event_in, .module_io_line_in, .pin_drive_out,
        .pin_route_out, .cpu_irq_out, .irq_out);
    count_source_model count_source_model_i (.clk_sys_in, .rst_in,
        .ext_count_out(ext_count_in), .ext_osc_out(ext_osc_in));

    // ==========================================
    // bus and check tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        @(posedge clk_sys_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= ad;
        reg_wdata_in <= wd;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] q);
        @(posedge clk_sys_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= ad;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        q = reg_rdata_out;
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] q;
        rd(ad, q);
        chk(q, exp);
    endtask
    // one cycle pulse on an event input, then settle
    task automatic pulse(input logic t0, input logic [4:0] ev);
        @(posedge clk_sys_in);
        timer0_ovf_in   <= t0;
        module_event_in <= ev;
        @(posedge clk_sys_in);
        timer0_ovf_in   <= 1'b0;
        module_event_in <= 5'h00;
        repeat (4) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang limit
    initial begin
        #2000000;
        err_total++;
        finish_test();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rdc(ADDR_MODE, MODE_RESET);
        rdc(8'h20, 8'h00);
        wr(ADDR_MODE, 8'h44);
        wr(ADDR_COUNT_HIGH, 8'h55);
        rd(ADDR_COUNT_LOW, a);
        rdc(ADDR_COUNT_HIGH, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(ADDR_MODE, mode_tab[i]);
            rd(ADDR_COUNT_LOW, a);
            repeat (94) @(posedge clk_sys_in);
            rd(ADDR_COUNT_LOW, d);
            chk(d - a, rate_tab[i]);
        end
        wr(ADDR_MODE, 8'h04);
        wr(ADDR_COUNT_LOW, 8'hff);
        wr(ADDR_COUNT_HIGH, 8'h12);
        rdc(ADDR_COUNT_LOW, 8'hff);
        pulse(1'b1, 5'h00);
        rdc(ADDR_COUNT_HIGH, 8'h12);
        rdc(ADDR_COUNT_LOW, 8'h00);
        rdc(ADDR_COUNT_HIGH, 8'h13);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_COUNT_LOW, 8'hff);
        rdc(ADDR_FLAGS, 8'h00);
        pulse(1'b1, 5'h00);
        rdc(ADDR_FLAGS, 8'h80);
        wr(ADDR_IRQ_CTRL, 8'h03);
        chk({7'h00, cpu_irq_out}, 8'h00);
        wr(ADDR_MODE, 8'h05);
        chk({7'h00, cpu_irq_out}, 8'h01);
        rdc(ADDR_FLAGS, 8'h80);
        wr(ADDR_FLAGS, 8'h00);
        chk({7'h00, cpu_irq_out}, 8'h00);
        pulse(1'b0, 5'h04);
        rdc(ADDR_FLAGS, 8'h04);
        chk({7'h00, cpu_irq_out}, 8'h00);
        wr(ADDR_MODULE_IEN, 8'h04);
        chk({7'h00, cpu_irq_out}, 8'h01);
        wr(ADDR_IRQ_CTRL, 8'h02);
        chk({7'h00, cpu_irq_out}, 8'h00);
        // sticky status, mask and clear
        rdc(ADDR_IRQ_STATUS, 8'h07);
        wr(ADDR_IRQ_MASK, 8'h02);
        chk({7'h00, irq_out}, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h02);
        wr(ADDR_IRQ_STATUS, 8'h02);
        chk({7'h00, irq_out}, 8'h00);
        rdc(ADDR_IRQ_STATUS, 8'h05);
        wr(ADDR_MODULE_IOEN, 8'h05);
        repeat (2) @(posedge clk_sys_in);
        #1;
        chk({3'h0, pin_route_out}, 8'h05);
        chk({3'h0, pin_drive_out}, 8'h01);
        finish_test();
    end
endmodule
